// >>> pkg/dac_cmd_pkg.sv
// Purpose: shared constants for the dual converter command decoder
// Assumes: 16-bit command words, two 12-bit channels
// Notes:   channel index 0 is channel A, index 1 is channel B
//
// Behaviour
// - 00, pair 0: store channel A input
// - 00, pair 1: store channel B input
// - 01, pair 0: update channel A fully
// - 01, pair 1: update A, copy B
// - 10, pair 0: update channel B fully
// - 10, pair 1: update B, copy A
// - 11, pair 0: update both with data
// - 11, pair 1: copy both inputs, data dropped
// - mode bit one: power down, pick termination
// - power-down channel chosen by load bits
// - output code is unsigned twelve-bit value
// - power-up clears every channel register to zero
// - outputs stay zero until first valid word
// - sixteen bits, msb first, falling clock edges
// - normal mode: apply at sixteenth edge
// - chain mode: delayed echo, apply on rise
// - clear resets link and channel registers, resumes after sync rise
package dac_cmd_pkg;

  localparam int          WORD_W    = 16;
  localparam int          DATA_W    = 12;
  localparam int          CHAN_N    = 2;
  localparam int          CNT_W     = 5;
  localparam int          SYNC_W    = 5;

  // command word field positions
  localparam int          LC_HI_POS = 15;
  localparam int          LC_LO_POS = 14;
  localparam int          PAIR_POS  = 13;
  localparam int          MODE_POS  = 12;
  localparam int          TERM_HI   = 11;
  localparam int          TERM_LO   = 10;
  localparam int          MSB_POS   = 15;
  localparam int          LAST_POS  = 14;

  // bit counter figures
  localparam logic [4:0]  BIT_CNT_ZERO = 5'h00;
  localparam logic [4:0]  BIT_CNT_ONE  = 5'h01;
  localparam logic [4:0]  BIT_CNT_LAST = 5'h0F;
  localparam logic [4:0]  BIT_CNT_FULL = 5'h10;

  // load-control codes
  localparam logic [1:0]  LC_STORE  = 2'h0;
  localparam logic [1:0]  LC_UPD_A  = 2'h1;
  localparam logic [1:0]  LC_UPD_B  = 2'h2;
  localparam logic [1:0]  LC_ALL    = 2'h3;

  // termination codes during power-down
  localparam logic [1:0]  TERM_FLOAT     = 2'h0;
  localparam logic [1:0]  TERM_1K        = 2'h1;
  localparam logic [1:0]  TERM_100K      = 2'h2;
  localparam logic [1:0]  TERM_FLOAT_ALT = 2'h3;

  // code range of an output register
  localparam logic [11:0] ZERO_CODE  = 12'h000;
  localparam logic [11:0] FULL_CODE  = 12'hFFF;
  localparam int          CODE_STEPS = 4096;
  localparam logic [15:0] WORD_ZERO  = 16'h0000;

  typedef enum logic {ST_CLEARED, ST_ARMED} arm_state_e;

endpackage : dac_cmd_pkg

// >>> rtl/bit_sync.sv
// Purpose: two-flop level synchroniser for a group of bits
// Assumes: each bit is a slow level, independent of the others
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk_in,
  input  wire logic         rst_n_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  // two stages; reset value high matches idle pins
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      meta_r   <= '1;
      sync_out <= '1;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : bit_sync

// >>> rtl/serial_link.sv
// Purpose: shift register and bit counter on the serial clock
// Assumes: serial clock stands still outside frames
// Notes:   frame sync high clears the counter without a clock edge
`timescale 1ns/1ps
module serial_link (
  input  wire logic                          sclk_in,
  input  wire logic                          lrst_n_in,
  input  wire logic                          sync_n_in,
  input  wire logic                          serial_in,
  input  wire logic                          chain_enable_in,
  output logic [dac_cmd_pkg::WORD_W-1:0]     word_hold_out,
  output logic [dac_cmd_pkg::WORD_W-1:0]     shift_out,
  output logic                               done_toggle_out,
  output logic                               chain_full_out,
  output logic                               serial_out,
  output logic                               serial_oe_out
);
  import dac_cmd_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  wire              cnt_full  = (cnt_r == BIT_CNT_FULL);
  // normal mode stops after sixteen bits, chain mode keeps going
  wire              shift_en  = !sync_n_in && (chain_enable_in || !cnt_full);
  wire              last_bit  = !chain_enable_in && (cnt_r == BIT_CNT_LAST);
  wire [WORD_W-1:0] shift_nxt = {shift_out[LAST_POS:0], serial_in};

  assign cnt_nxt = cnt_full ? cnt_r : cnt_r + BIT_CNT_ONE;

  // partial word dropped
  // counter and echo enable die as soon as sync rises
  always_ff @(negedge sclk_in or negedge lrst_n_in or posedge sync_n_in) begin
    if (!lrst_n_in || sync_n_in) begin
      cnt_r         <= BIT_CNT_ZERO;
      serial_oe_out <= 1'b0;
    end else begin
      cnt_r         <= cnt_nxt;
      serial_oe_out <= chain_enable_in;
    end
  end

  always_ff @(negedge sclk_in or negedge lrst_n_in) begin
    if (!lrst_n_in) begin
      shift_out       <= WORD_ZERO;
      word_hold_out   <= WORD_ZERO;
      done_toggle_out <= 1'b0;
      chain_full_out  <= 1'b0;
      serial_out      <= 1'b0;
    end else if (shift_en) begin
      shift_out       <= shift_nxt;
      serial_out      <= shift_out[MSB_POS];
      chain_full_out  <= (cnt_nxt == BIT_CNT_FULL);
      if (last_bit) begin
        word_hold_out   <= shift_nxt;
        done_toggle_out <= !done_toggle_out;
      end
    end
  end

endmodule : serial_link

// >>> rtl/dac_cmd_decoder.sv
// Purpose: decode serial command words into two converter channels
// Assumes: mclk_in much faster than frame sync high time
// Notes:   link logic runs on sclk_in, words cross by toggle or by
//          the quiet shift register after frame sync rises
`timescale 1ns/1ps
module dac_cmd_decoder (
  input  wire logic                          mclk_in,
  input  wire logic                          rst_n_in,
  input  wire logic                          sclk_in,
  input  wire logic                          sync_n_in,
  input  wire logic                          serial_in,
  input  wire logic                          chain_enable_in,
  input  wire logic                          async_clear_n_in,
  output logic                               serial_out,
  output logic                               serial_oe_out,
  output logic [dac_cmd_pkg::DATA_W-1:0]     out_code_a_out,
  output logic [dac_cmd_pkg::DATA_W-1:0]     out_code_b_out,
  output logic [dac_cmd_pkg::DATA_W-1:0]     in_code_a_out,
  output logic [dac_cmd_pkg::DATA_W-1:0]     in_code_b_out,
  output logic                               power_down_a_out,
  output logic                               power_down_b_out,
  output logic [1:0]                         termination_a_out,
  output logic [1:0]                         termination_b_out,
  output logic                               word_applied_out
);
  import dac_cmd_pkg::*;

  // ---------------------------------------------------------------
  // link side
  // ---------------------------------------------------------------
  logic              link_rst_n_r;
  logic [WORD_W-1:0] word_hold;
  logic [WORD_W-1:0] word_shift;
  logic              done_toggle;
  logic              chain_full;
  logic              link_sdo;
  logic              link_oe;

  // link reset: power-on reset one mclk later, or the clear pin at once
  wire lrst_n = link_rst_n_r && async_clear_n_in;

  always_ff @(posedge mclk_in) begin
    link_rst_n_r <= rst_n_in;
  end

  serial_link u_link (
    .sclk_in         (sclk_in),
    .lrst_n_in       (lrst_n),
    .sync_n_in       (sync_n_in),
    .serial_in       (serial_in),
    .chain_enable_in (chain_enable_in),
    .word_hold_out   (word_hold),
    .shift_out       (word_shift),
    .done_toggle_out (done_toggle),
    .chain_full_out  (chain_full),
    .serial_out      (link_sdo),
    .serial_oe_out   (link_oe)
  );

  // echo pin is a link-domain flop; it follows falling sclk edges
  assign serial_out    = link_sdo;
  assign serial_oe_out = link_oe;

  // ---------------------------------------------------------------
  // crossing into mclk
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] raw_lv;
  logic [SYNC_W-1:0] sync_lv;
  logic              sync_n_prev_r;
  logic              toggle_prev_r;

  assign raw_lv = {sync_n_in, done_toggle, chain_full,
                   chain_enable_in, async_clear_n_in};

  bit_sync #(.W(SYNC_W)) u_sync (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .async_in (raw_lv),
    .sync_out (sync_lv)
  );

  wire sync_n_s  = sync_lv[4];
  wire toggle_s  = sync_lv[3];
  wire full_s    = sync_lv[2];
  wire chain_s   = sync_lv[1];
  wire clear_n_s = sync_lv[0];

  // edge history taken from the second stage only
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sync_n_prev_r <= 1'b1;
      toggle_prev_r <= 1'b0;
    end else begin
      sync_n_prev_r <= sync_n_s;
      toggle_prev_r <= toggle_s;
    end
  end

  wire sync_rise  = sync_n_s && !sync_n_prev_r;
  wire toggle_evt = (toggle_s != toggle_prev_r);

  // ---------------------------------------------------------------
  // arming after clear or power-on
  // ---------------------------------------------------------------
  arm_state_e state_r;
  arm_state_e state_nxt;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_CLEARED: begin
        if (sync_rise) begin
          state_nxt = ST_ARMED;
        end
      end
      ST_ARMED: begin
        state_nxt = ST_ARMED;
      end
    endcase
  end

  // power-on leaves block unarmed
  // a normal-mode word already in flight at reset release is not trusted
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || !clear_n_s) begin
      state_r <= ST_CLEARED;
    end else begin
      state_r <= state_nxt;
    end
  end

  wire armed = (state_r == ST_ARMED);

  wire norm_evt  = armed && toggle_evt && !chain_s;
  // chain word on sync rise
  // the shift register is quiet once sync is high, so it is stable
  wire chain_evt = sync_rise && chain_s && full_s;
  wire apply     = clear_n_s && (norm_evt || chain_evt);

  wire [WORD_W-1:0] word = chain_evt ? word_shift : word_hold;

  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  wire [1:0]        lc     = word[LC_HI_POS:LC_LO_POS];
  wire              pair   = word[PAIR_POS];
  wire              mode   = word[MODE_POS];
  wire [1:0]        term   = word[TERM_HI:TERM_LO];
  wire [DATA_W-1:0] data   = word[DATA_W-1:0];
  wire              normal = apply && !mode;
  wire              power_down_select    = apply && mode;

  wire lc_store = (lc == LC_STORE);
  wire lc_upd_a = (lc == LC_UPD_A);
  wire lc_upd_b = (lc == LC_UPD_B);
  wire lc_all   = (lc == LC_ALL);

  // per-channel strobes, index 0 is A and index 1 is B
  logic [CHAN_N-1:0] in_ld;
  logic [CHAN_N-1:0] out_ld;
  logic [CHAN_N-1:0] out_cp;
  logic [CHAN_N-1:0] pd_sel;

  assign in_ld[0]  = normal && ((lc_store && !pair) || lc_upd_a ||
                                (lc_all && !pair));
  assign in_ld[1]  = normal && ((lc_store && pair) || lc_upd_b ||
                                (lc_all && !pair));
  assign out_ld[0] = normal && (lc_upd_a || (lc_all && !pair));
  assign out_ld[1] = normal && (lc_upd_b || (lc_all && !pair));
  // copy input to output
  // the copy reads the old input, data bits are not stored there
  assign out_cp[0] = normal && pair && (lc_upd_b || lc_all);
  assign out_cp[1] = normal && pair && (lc_upd_a || lc_all);
  assign pd_sel[0] = power_down_select && !lc_upd_b;
  assign pd_sel[1] = power_down_select && !lc_upd_a;

  // ---------------------------------------------------------------
  // channel registers
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] in_r    [CHAN_N];
  logic [DATA_W-1:0] in_nxt  [CHAN_N];
  logic [DATA_W-1:0] out_r   [CHAN_N];
  logic [DATA_W-1:0] out_nxt [CHAN_N];
  logic [CHAN_N-1:0] pd_r;
  logic [CHAN_N-1:0] pd_nxt;
  logic [1:0]        term_r   [CHAN_N];
  logic [1:0]        term_nxt [CHAN_N];

  for (genvar ch = 0; ch < CHAN_N; ch++) begin : g_chan
    assign in_nxt[ch]   = in_ld[ch] ? data : in_r[ch];
    assign out_nxt[ch]  = out_ld[ch] ? data :
                          out_cp[ch] ? in_r[ch] : out_r[ch];
    // output load wakes channel
    // codes are kept through power-down, only the flag and termination move
    assign pd_nxt[ch]   = pd_sel[ch] ? 1'b1 :
                          (out_ld[ch] || out_cp[ch]) ? 1'b0 : pd_r[ch];
    assign term_nxt[ch] = pd_sel[ch] ? term : term_r[ch];

    always_ff @(posedge mclk_in) begin
      if (!rst_n_in || !clear_n_s) begin
        in_r[ch]   <= ZERO_CODE;
        out_r[ch]  <= ZERO_CODE;
        pd_r[ch]   <= 1'b0;
        term_r[ch] <= TERM_FLOAT;
      end else begin
        in_r[ch]   <= in_nxt[ch];
        out_r[ch]  <= out_nxt[ch];
        pd_r[ch]   <= pd_nxt[ch];
        term_r[ch] <= term_nxt[ch];
      end
    end
  end

  // results update together
  // one mclk edge moves every channel, so no half-applied word shows
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || !clear_n_s) begin
      word_applied_out <= 1'b0;
    end else begin
      word_applied_out <= apply;
    end
  end

  // ports read straight from the channel flops
  assign out_code_a_out    = out_r[0];
  assign out_code_b_out    = out_r[1];
  assign in_code_a_out     = in_r[0];
  assign in_code_b_out     = in_r[1];
  assign power_down_a_out  = pd_r[0];
  assign power_down_b_out  = pd_r[1];
  assign termination_a_out = term_r[0];
  assign termination_b_out = term_r[1];

endmodule : dac_cmd_decoder

// >>> dv/dac_cmd_decoder_sva.sv
// Purpose: port checks for the command decoder
// Assumes: one mclk domain, chain level static
// Notes:   clear effects are masked a few cycles
`timescale 1ns/1ps
module dac_cmd_decoder_sva (
  input wire logic                      mclk_in,
  input wire logic                      rst_n_in,
  input wire logic                      sclk_in,
  input wire logic                      sync_n_in,
  input wire logic                      serial_in,
  input wire logic                      chain_enable_in,
  input wire logic                      async_clear_n_in,
  input wire logic                      serial_out,
  input wire logic                      serial_oe_out,
  input wire logic [dac_cmd_pkg::DATA_W-1:0] out_code_a_out,
  input wire logic [dac_cmd_pkg::DATA_W-1:0] out_code_b_out,
  input wire logic [dac_cmd_pkg::DATA_W-1:0] in_code_a_out,
  input wire logic [dac_cmd_pkg::DATA_W-1:0] in_code_b_out,
  input wire logic                      power_down_a_out,
  input wire logic                      power_down_b_out,
  input wire logic [1:0]                termination_a_out,
  input wire logic [1:0]                termination_b_out,
  input wire logic                      word_applied_out
);
  import dac_cmd_pkg::*;
  logic [2:0] quiet_r;
  logic [2:0] quiet_nxt;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // cycles since clear was low, saturates at seven
  assign quiet_nxt = !async_clear_n_in ? 3'h0 :
                     (quiet_r == 3'h7) ? quiet_r : quiet_r + 3'h1;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) quiet_r <= 3'h7;
    else quiet_r <= quiet_nxt;
  end
  sequence clear_held;
    !async_clear_n_in [*3];
  endsequence
  sequence any_change;
    $changed(out_code_a_out) || $changed(out_code_b_out) ||
    $changed(power_down_a_out) || $changed(power_down_b_out);
  endsequence
  chk_reset_zero: assert property ($rose(rst_n_in) |->
    out_code_a_out == ZERO_CODE && out_code_b_out == ZERO_CODE &&
    !power_down_a_out && !power_down_b_out)
    else $error("outputs not zero after reset");
  chk_clear_zero: assert property (clear_held |=>
    out_code_a_out == ZERO_CODE && out_code_b_out == ZERO_CODE &&
    in_code_a_out == ZERO_CODE && !power_down_b_out)
    else $error("clear did not zero the registers");
  chk_pulse_single: assert property (word_applied_out |=>
    !word_applied_out) else $error("applied pulse too long");
  chk_change_cause: assert property (any_change ##0 quiet_r == 3'h7 |->
    word_applied_out) else $error("outputs changed without a word");
  chk_out_a_tracks: assert property ($changed(out_code_a_out) |->
    out_code_a_out == in_code_a_out) else $error("out A differs from in A");
  chk_out_b_tracks: assert property ($changed(out_code_b_out) |->
    out_code_b_out == in_code_b_out) else $error("out B differs from in B");
  chk_load_wakes: assert property ($changed(out_code_a_out) |->
    !power_down_a_out) else $error("load left channel A down");
  chk_pd_by_word: assert property ($rose(power_down_b_out) |->
    word_applied_out) else $error("power-down without a word");
  chk_term_pd_only: assert property ($changed(termination_a_out) &&
    quiet_r == 3'h7 |-> power_down_a_out)
    else $error("termination changed outside power-down");
  chk_oe_quiet: assert property (sync_n_in || !chain_enable_in |->
    !serial_oe_out) else $error("serial output driven out of frame");
endmodule : dac_cmd_decoder_sva
bind dac_cmd_decoder dac_cmd_decoder_sva dac_cmd_decoder_sva_i (
  .mclk_in, .rst_n_in, .sclk_in, .sync_n_in, .serial_in, .chain_enable_in,
  .async_clear_n_in, .serial_out, .serial_oe_out, .out_code_a_out,
  .out_code_b_out, .in_code_a_out, .in_code_b_out, .power_down_a_out,
  .power_down_b_out, .termination_a_out, .termination_b_out,
  .word_applied_out);

// >>> dv/host_serial_model.sv
// Purpose: host controller sending framed serial words
// Assumes: clock idles high, one spare pulse after sync rise, then still
// Notes:   released data line shows the inverse of its last bit
`timescale 1ns/1ps
module host_serial_model #(
  parameter int HALF_NS = 16
) (
  output logic sclk_out,
  output logic sync_n_out,
  output logic data_out
);
  initial begin
    sclk_out = 1'b1;
    sync_n_out = 1'b1;
    data_out = 1'b0;
  end
  // sync low, then n bits msb first on falling edges
  task automatic frame(input logic [31:0] bits, input int n);
    int i;
    #(7);
    sync_n_out = 1'b0;
    for (i = n - 1; i >= 0; i--) begin
      data_out = bits[i];
      #(HALF_NS);
      sclk_out = 1'b0;
      #(HALF_NS);
      sclk_out = 1'b1;
    end
    #(HALF_NS);
    sync_n_out = 1'b1;
    data_out = ~data_out;
    // spare pulse after sync rise; the link ignores it while sync is high
    #(HALF_NS);
    sclk_out = 1'b0;
    #(HALF_NS);
    sclk_out = 1'b1;
    #(400);
  endtask : frame
endmodule : host_serial_model

// >>> dv/tb_top.sv
// Purpose: directed bench for the command decoder
// Assumes: host model makes the serial frames
// Notes:   expected state kept in a small reference model
`timescale 1ns/1ps
module tb_top;
  import dac_cmd_pkg::*;
  localparam int LIMIT = 5000; // run needs under a thousand cycles
  logic mclk_in, rst_n_in, sclk, sync_n, sdata, chain_en, clear_n;
  logic so, soe, pa, pb, wa, epa, epb;
  logic [DATA_W-1:0] oa, ob, ia, ib, ea, eb, xa, xb;
  logic [1:0] ta, tbt, eta, etb;
  int fails, compares, napp, eapp, cyc, c;
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  dac_cmd_decoder dac_cmd_decoder_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .sclk_in(sclk), .sync_n_in(sync_n), .serial_in(sdata),
    .chain_enable_in(chain_en), .async_clear_n_in(clear_n),
    .serial_out(so), .serial_oe_out(soe), .out_code_a_out(oa),
    .out_code_b_out(ob), .in_code_a_out(ia), .in_code_b_out(ib),
    .power_down_a_out(pa), .power_down_b_out(pb), .termination_a_out(ta),
    .termination_b_out(tbt), .word_applied_out(wa));
  host_serial_model host_serial_model_i (.sclk_out(sclk),
    .sync_n_out(sync_n), .data_out(sdata));
  task automatic summarize;
    if (fails == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // count cycles and applied pulses
  always @(posedge mclk_in) begin
    cyc++;
    if (wa === 1'b1) napp++;
    if (cyc == LIMIT) begin
      fails++;
      summarize();
    end
  end
  task automatic cmp(input string nm, input logic [11:0] e, g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : cmp
  // link shadow: echo repeats the bit sent sixteen edges back
  logic [16:0] echo_r;
  int          edges;
  always @(negedge sclk or posedge sync_n) begin
    if (sync_n) begin
      edges <= 0;
    end else begin
      echo_r <= {echo_r[15:0], sdata};
      edges  <= edges + 1;
    end
  end
  // looked at on the rising sclk, half a bit after the echo flop moved
  always @(posedge sclk) begin
    if (!sync_n && chain_en && edges > 16) begin
      cmp("serial_out", {11'h0, echo_r[16]}, {11'h0, so});
      cmp("serial_oe", 12'h001, {11'h0, soe});
    end
  end
  task automatic check_all;
    @(negedge mclk_in);
    cmp("out_code_a", ea, oa);
    cmp("out_code_b", eb, ob);
    cmp("in_code_a", xa, ia);
    cmp("in_code_b", xb, ib);
    cmp("power_down", {10'h0, epa, epb}, {10'h0, pa, pb});
    cmp("termination", {8'h0, eta, etb}, {8'h0, ta, tbt});
    cmp("applied_count", 12'(eapp), 12'(napp));
  endtask : check_all
  task automatic model_reset;
    {ea, eb, xa, xb, epa, epb, eta, etb} = '0;
  endtask : model_reset
  // reference decode of one applied word
  task automatic model(input logic [15:0] w);
    logic [11:0] d;
    d = w[11:0];
    eapp++;
    if (w[12]) begin
      if (w[15:14] != LC_UPD_B) {epa, eta} = {1'b1, w[11:10]};
      if (w[15:14] != LC_UPD_A) {epb, etb} = {1'b1, w[11:10]};
    end else case (w[15:14])
      LC_STORE: if (w[13]) xb = d; else xa = d;
      LC_UPD_A: begin
        {xa, ea, epa} = {d, d, 1'b0};
        if (w[13]) {eb, epb} = {xb, 1'b0};
      end
      LC_UPD_B: begin
        {xb, eb, epb} = {d, d, 1'b0};
        if (w[13]) {ea, epa} = {xa, 1'b0};
      end
      default: begin
        if (!w[13]) {xa, xb} = {d, d};
        {ea, eb, epa, epb} = {xa, xb, 2'b00};
      end
    endcase
  endtask : model
  task automatic send(input logic [15:0] w, input bit applies);
    host_serial_model_i.frame({16'h0, w}, 16);
    if (applies) model(w);
    check_all();
  endtask : send
  initial begin
    {rst_n_in, chain_en, clear_n} = 3'b001;
    {fails, compares, napp, eapp, cyc} = '0;
    model_reset();
    repeat (10) @(negedge mclk_in);
    rst_n_in = 1'b1;
    check_all();
    send(16'h3123, 1'b0);
    // every channel choice with every termination code
    for (c = 0; c < 16; c++) send({c[3:2], 2'b11, c[1:0], 10'h2A5}, 1'b1);
    // every normal load code, full scale at the update-both code
    for (c = 0; c < 8; c++) send({c[2:0], 1'b0,
      (c == 6) ? FULL_CODE : 12'h1A3 + 12'(c) * 12'h102}, 1'b1);
    // inputs made to differ from outputs, so the copy shows
    send(16'h0ABC, 1'b1);
    send(16'h2DEF, 1'b1);
    send(16'hE555, 1'b1);
    host_serial_model_i.frame(32'(16'hC7BC >> 1), 15);
    check_all();
    chain_en = 1'b1;
    host_serial_model_i.frame(32'hC111_C5C3, 32);
    model(16'hC5C3);
    check_all();
    host_serial_model_i.frame(32'h0000_0C3C, 12);
    check_all();
    chain_en = 1'b0;
    clear_n = 1'b0;
    repeat (6) @(negedge mclk_in);
    clear_n = 1'b1;
    model_reset();
    check_all();
    send(16'hC777, 1'b0);
    send(16'hC777, 1'b1);
    summarize();
  end
endmodule : tb_top
